// ===== src/vdet_pkg.sv
// shared constants and carrier types of the low-voltage detect controller
// assumes a single 10 MHz clock domain and 8-bit registers on a 32-bit bus
package vdet_pkg;

    // ************************************************
    // register byte offsets on the avalon slave
    // ************************************************
    localparam int unsigned VDET_AW = 6;
    localparam logic [5:0] VDET_OFF_CTRL = 6'h00;   // detector control
    localparam logic [5:0] VDET_OFF_FLAGS = 6'h04;  // peripheral flags b
    localparam logic [5:0] VDET_OFF_ENABLES = 6'h08; // peripheral enables b
    localparam logic [5:0] VDET_OFF_PRIO = 6'h0c;   // peripheral priority b
    localparam logic [5:0] VDET_OFF_CORE = 6'h10;   // core irq control
    localparam logic [5:0] VDET_OFF_EVT_STAT = 6'h14; // sticky status, ro
    localparam logic [5:0] VDET_OFF_EVT_CLR = 6'h18;  // clear, wo
    localparam logic [5:0] VDET_OFF_EVT_EN = 6'h1c;   // event enables

    // ************************************************
    // field positions
    // ************************************************
    localparam int unsigned VDET_STABLE_BIT = 5;  // reference stable, ro
    localparam int unsigned VDET_PWR_BIT = 4;     // detector power enable
    localparam int unsigned VDET_TRIP_MSB = 3;    // trip select 3..0
    localparam int unsigned VDET_LOWV_BIT = 2;    // flag/enable/priority
    localparam int unsigned VDET_GIE_BIT = 7;     // global irq enable
    localparam int unsigned VDET_EVT_TRIP = 0;    // status: trip seen
    localparam int unsigned VDET_EVT_STABLE = 1;  // status: ref settled
    localparam int unsigned VDET_EVT_W = 2;       // status width
    localparam int unsigned VDET_SYNC_W = 2;      // analog inputs synced

    // ************************************************
    // reset values and codes
    // ************************************************
    localparam logic [3:0] VDET_TRIP_RST = 4'h5;      // trip select at reset
    localparam logic [3:0] VDET_TRIP_RESERVED = 4'hf; // unusable code
    localparam logic [7:0] VDET_REG_RST = 8'h00;      // other registers

    // ************************************************
    // carrier types
    // ************************************************
    typedef struct packed {
        logic power_en;       // comparator and divider powered
        logic [3:0] trip_sel; // divider tap
    } vdet_ana_ctrl_t;

    typedef struct packed {
        logic ref_ready;  // internal reference has settled
        logic trip;       // supply at or below the trip point
    } vdet_ana_stat_t;

endpackage

// ===== src/vdet_sync3.sv
// three-stage synchroniser with agreement filter for the analog inputs
// assumes inputs are asynchronous levels from the analog front end
`timescale 1ns/1ps
module vdet_sync3
    import vdet_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [VDET_SYNC_W-1:0] async_i,
    output logic [VDET_SYNC_W-1:0] level_o
);

    // ************************************************
    // per-bit chain
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < VDET_SYNC_W; g++) begin : g_bit
            logic meta_ff; // first stage, read only by the second
            logic s2_ff;   // second stage
            logic s3_ff;   // third stage
            logic lvl_ff;  // accepted level
            // shift chain, frozen with the clock enable
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    meta_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                end else if (clk_en_i) begin
                    meta_ff <= async_i[g];
                    s2_ff <= meta_ff;
                    s3_ff <= s2_ff;
                end
            end
            // change counts only once stages two and three agree
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    lvl_ff <= 1'b0;
                end else if (clk_en_i && (s2_ff == s3_ff)) begin
                    lvl_ff <= s3_ff;
                end
            end
            assign level_o[g] = lvl_ff;
        end
    endgenerate

endmodule

// ===== src/vdet_evt_irq.sv
// sticky event status with write-one-to-clear and enable gating
// assumes set and clear pulses come from the same clock domain
`timescale 1ns/1ps
module vdet_evt_irq
    import vdet_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [VDET_EVT_W-1:0] set_i,
    input wire logic [VDET_EVT_W-1:0] clr_i,
    input wire logic [VDET_EVT_W-1:0] en_i,
    output logic [VDET_EVT_W-1:0] status_o,
    output logic irq_o
);

    // ************************************************
    // sticky bits
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < VDET_EVT_W; g++) begin : g_evt
            logic st_ff; // sticky status bit
            // set wins over a clear in the same cycle
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    st_ff <= 1'b0;
                end else if (clk_en_i) begin
                    st_ff <= set_i[g] | (st_ff & ~clr_i[g]);
                end
            end
            assign status_o[g] = st_ff;
        end
    endgenerate

    // level interrupt while any enabled bit is set
    assign irq_o = |(status_o & en_i);

endmodule

// ===== src/vdet_ctrl.sv
// low-voltage detect controller: registers, settle tracking, trip flag
// assumes avalon-mm master on clock_i; analog front end is asynchronous
//
// Contract
// - bit 4 powers comparator and divider
// - bits 3..0 select trip, 1111 reserved
// - bit 5 read-only reference stable flag
// - wait for settle after every enable
// - no interrupt before reference is stable; a flag set by a software write still raises vector_req_o
// - settle taken from analog ready, not count
// - trips during settling are not latched
// - stable enabled trip sets the flag
// - flag with enable requests an interrupt
// - flag, enable, priority at bit 2
// - detector trips wake the core from sleep
// - vector only when global enable set
// - reset returns control register, detector off
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module vdet_ctrl
    import vdet_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // avalon-mm slave
    input wire logic [VDET_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // analog front end
    input wire vdet_ana_stat_t ana_stat_i,
    output vdet_ana_ctrl_t ana_ctrl_o,
    // core side
    input wire logic sleep_i,
    output logic wake_o,
    output logic vector_req_o,
    output logic vector_high_prio_o,
    output logic irq_o
);

    // ************************************************
    // state
    // ************************************************
    logic power_en_ff;        // detector power enable
    logic [3:0] trip_sel_ff;  // trip point select
    logic ref_stable_ff;      // reference settled since last enable
    logic ref_wait_low_ff;    // set while powered off; after enable, wait for ready to drop
    logic lowv_flag_ff;       // sticky low-voltage flag
    logic lowv_ie_ff;         // low-voltage irq enable
    logic lowv_ip_ff;         // low-voltage irq priority
    logic gie_ff;             // global irq enable
    logic [VDET_EVT_W-1:0] evt_en_ff; // event enables
    logic ack_ff;             // bus answer cycle
    logic [31:0] rdata_ff;    // registered read data

    logic [VDET_SYNC_W-1:0] ana_sync; // synchronised analog levels
    logic ref_ready_s;        // reference ready, synced
    logic trip_s;             // comparator trip, synced
    logic req;                // bus request present
    logic wr_take;            // write takes effect this edge
    logic [7:0] wbyte;        // write byte lane 0
    logic [7:0] rd_mux;       // selected register value
    logic trip_evt;           // qualified trip this cycle
    logic stable_evt;         // stable flag rises this cycle
    logic [VDET_EVT_W-1:0] evt_set; // event set pulses
    logic [VDET_EVT_W-1:0] evt_clr; // event clear strobes
    logic [VDET_EVT_W-1:0] evt_status; // sticky event status
    logic evt_irq;            // enabled sticky event pending

    // ************************************************
    // input synchronisation
    // ************************************************
    // both analog levels come from outside the clock domain
    vdet_sync3 u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i({ana_stat_i.ref_ready, ana_stat_i.trip}),
        .level_o(ana_sync)
    );
    assign ref_ready_s = ana_sync[1];
    assign trip_s = ana_sync[0];

    // ************************************************
    // avalon handshake
    // ************************************************
    assign req = avs_read_i | avs_write_i;
    // one wait cycle, then the answer; keeps read data registered
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr_take = clk_en_i & avs_write_i & ack_ff & avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];
    assign avs_readdata_o = rdata_ff;

    // answer flop toggles on each pending request
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ack_ff <= 1'b0;
        end else if (clk_en_i) begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // ************************************************
    // read mux
    // ************************************************
    // bits 7..6 of control and unused flag bits read as zero
    always_comb begin
        rd_mux = 8'h00;
        case (avs_address_i & 6'h3c)
            VDET_OFF_CTRL: begin
                rd_mux[VDET_STABLE_BIT] = ref_stable_ff;
                rd_mux[VDET_PWR_BIT] = power_en_ff;
                rd_mux[VDET_TRIP_MSB:0] = trip_sel_ff;
            end
            VDET_OFF_FLAGS: begin
                rd_mux[VDET_LOWV_BIT] = lowv_flag_ff;
            end
            VDET_OFF_ENABLES: begin
                rd_mux[VDET_LOWV_BIT] = lowv_ie_ff;
            end
            VDET_OFF_PRIO: begin
                rd_mux[VDET_LOWV_BIT] = lowv_ip_ff;
            end
            VDET_OFF_CORE: begin
                rd_mux[VDET_GIE_BIT] = gie_ff;
            end
            VDET_OFF_EVT_STAT: begin
                rd_mux[VDET_EVT_W-1:0] = evt_status;
            end
            VDET_OFF_EVT_EN: begin
                rd_mux[VDET_EVT_W-1:0] = evt_en_ff;
            end
            default: begin
                // clear register and unmapped space read zero
                rd_mux = 8'h00;
            end
        endcase
    end

    // capture in the wait cycle, stands at the answer
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 32'h00000000;
        end else if (clk_en_i && avs_read_i && !ack_ff) begin
            rdata_ff <= {24'h000000, rd_mux};
        end
    end

    // ************************************************
    // control register
    // ************************************************
    // reset turns the detector off and restores the trip select
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            power_en_ff <= 1'b0;
            trip_sel_ff <= VDET_TRIP_RST;
        end else if (wr_take && avs_address_i[5:2] == VDET_OFF_CTRL[5:2]) begin
            power_en_ff <= wbyte[VDET_PWR_BIT];
            // reserved code is refused, the old tap stays selected
            if (wbyte[VDET_TRIP_MSB:0] != VDET_TRIP_RESERVED) begin
                trip_sel_ff <= wbyte[VDET_TRIP_MSB:0];
            end
        end
    end

    // drive the analog front end from the control register
    assign ana_ctrl_o.power_en = power_en_ff;
    assign ana_ctrl_o.trip_sel = trip_sel_ff;

    // ************************************************
    // reference settle tracking
    // ************************************************
    // settle time is analog, so no counter;
    // stale ready from before the enable is not trusted
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ref_wait_low_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (!power_en_ff) begin
                ref_wait_low_ff <= 1'b1;
            end else if (!ref_ready_s) begin
                ref_wait_low_ff <= 1'b0;
            end
        end
    end

    // stable flag sets on analog ready once powered and re-armed, held until power off
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ref_stable_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (!power_en_ff) begin
                ref_stable_ff <= 1'b0;
            end else if (ref_ready_s && !ref_wait_low_ff) begin
                ref_stable_ff <= 1'b1;
            end
        end
    end

    // ************************************************
    // low-voltage flag
    // ************************************************
    // trips are ignored until powered and settled
    assign trip_evt = power_en_ff & ref_stable_ff & trip_s;
    assign stable_evt = power_en_ff & ref_ready_s & ~ref_wait_low_ff
                        & ~ref_stable_ff;

    // sticky; a trip in the cycle of a software clear still sets it
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lowv_flag_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (trip_evt) begin
                lowv_flag_ff <= 1'b1;
            end else if (wr_take
                         && avs_address_i[5:2] == VDET_OFF_FLAGS[5:2]) begin
                lowv_flag_ff <= wbyte[VDET_LOWV_BIT];
            end
        end
    end

    // ************************************************
    // enable, priority and global enable
    // ************************************************
    // plain read-write bits at their fixed positions
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lowv_ie_ff <= 1'b0;
            lowv_ip_ff <= 1'b0;
            gie_ff <= 1'b0;
        end else if (wr_take) begin
            case (avs_address_i & 6'h3c)
                VDET_OFF_ENABLES: begin
                    lowv_ie_ff <= wbyte[VDET_LOWV_BIT];
                end
                VDET_OFF_PRIO: begin
                    lowv_ip_ff <= wbyte[VDET_LOWV_BIT];
                end
                VDET_OFF_CORE: begin
                    gie_ff <= wbyte[VDET_GIE_BIT];
                end
                default: begin
                    // other offsets leave these bits alone
                    lowv_ie_ff <= lowv_ie_ff;
                end
            endcase
        end
    end

    // event enable register of the sticky status block
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            evt_en_ff <= '0;
        end else if (wr_take
                     && avs_address_i[5:2] == VDET_OFF_EVT_EN[5:2]) begin
            evt_en_ff <= wbyte[VDET_EVT_W-1:0];
        end
    end

    // ************************************************
    // core interrupt and wake
    // ************************************************
    // a trip sets the flag only once stable; a software write can set it at any time
    assign vector_req_o = lowv_flag_ff & lowv_ie_ff & gie_ff;
    assign vector_high_prio_o = lowv_ip_ff;
    // wake does not need the global enable; core then runs in line
    assign wake_o = sleep_i & lowv_flag_ff & lowv_ie_ff;
    // combinational, so it works with the clock enable low

    // ************************************************
    // sticky event status
    // ************************************************
    assign evt_set[VDET_EVT_TRIP] = trip_evt;
    assign evt_set[VDET_EVT_STABLE] = stable_evt;
    // write-one-to-clear strobe, one per bit
    assign evt_clr = (wr_take
                      && avs_address_i[5:2] == VDET_OFF_EVT_CLR[5:2])
                     ? wbyte[VDET_EVT_W-1:0] : '0;

    vdet_evt_irq u_evt (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .set_i(evt_set),
        .clr_i(evt_clr),
        .en_i(evt_en_ff),
        .status_o(evt_status),
        .irq_o(evt_irq)
    );

    // limitation: this line reflects the sticky block, not the flag
    assign irq_o = evt_irq;

endmodule

// ===== tb/vdet_ctrl_properties.sv
// port checker of the low-voltage detect controller, bound to vdet_ctrl
// assumes one clock, synchronous active-high reset, clk_en_i held high
`timescale 1ns/1ps
module vdet_chk
    import vdet_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [VDET_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire vdet_ana_ctrl_t ana_ctrl_o,
    input wire logic sleep_i,
    input wire logic wake_o,
    input wire logic vector_req_o,
    input wire logic vector_high_prio_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    // ************************************************
    // derived bus events
    // ************************************************
    logic req;     // any request pending
    logic ctrl_wr; // control write taken at this edge
    assign req = avs_read_i | avs_write_i;
    assign ctrl_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0]
        & (avs_address_i[5:2] == VDET_OFF_CTRL[5:2]);

    // ************************************************
    // assertions
    // ************************************************
    chk_wait_one: assert property (req && !$past(req)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("late answer");
    chk_idle_quiet: assert property (!req |-> !avs_waitrequest_o)
        else $error("idle wait");
    chk_rdata_high: assert property (avs_read_i && !avs_waitrequest_o
        |-> avs_readdata_o[31:8] == 24'h0)
        else $error("rdata high");
    chk_power_bit: assert property (ctrl_wr
        |=> ana_ctrl_o.power_en == $past(avs_writedata_i[VDET_PWR_BIT]))
        else $error("power write");
    chk_trip_write: assert property (ctrl_wr |=> ana_ctrl_o.trip_sel ==
        (($past(avs_writedata_i[3:0]) == VDET_TRIP_RESERVED)
        ? $past(ana_ctrl_o.trip_sel) : $past(avs_writedata_i[3:0])))
        else $error("trip write");
    chk_ctrl_hold: assert property (!ctrl_wr |=> $stable(ana_ctrl_o))
        else $error("ctrl moved");
    chk_reset_off: assert property ($fell(sys_rst_i)
        |-> !ana_ctrl_o.power_en && ana_ctrl_o.trip_sel == VDET_TRIP_RST)
        else $error("reset state");
    chk_trip_legal: assert property (
        ana_ctrl_o.trip_sel != VDET_TRIP_RESERVED)
        else $error("reserved trip");
    chk_wake_asleep: assert property (wake_o |-> sleep_i)
        else $error("wake while awake");
    chk_vector_wake: assert property (vector_req_o && sleep_i |-> wake_o)
        else $error("no wake");
    chk_prio_write: assert property ($changed(vector_high_prio_o)
        |-> $past(avs_write_i & ~avs_waitrequest_o)
        && $past(avs_address_i[5:2]) == VDET_OFF_PRIO[5:2])
        else $error("prio moved");

    // ************************************************
    // scenario coverage
    // ************************************************
    cov_wake: cover property (wake_o);
    cov_vector: cover property (vector_req_o && !sleep_i);
    cov_ctrl_wr: cover property (ctrl_wr);
endmodule

bind vdet_ctrl vdet_chk u_chk (.clock_i, .sys_rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .ana_ctrl_o, .sleep_i, .wake_o,
    .vector_req_o, .vector_high_prio_o);

// ===== tb/vdet_ana_model.sv
// behavioural model of the analog comparator, divider and reference
// assumes ctrl_i comes straight from the controller's registers
`timescale 1ns/1ps
module vdet_ana_model
    import vdet_pkg::*;
(
    input wire logic clock_i,
    input wire vdet_ana_ctrl_t ctrl_i,
    input wire logic [7:0] settle_i, // reference start-up, cycles, >0
    input wire logic supply_low_i,   // supply at or below trip point
    output vdet_ana_stat_t stat_o
);
    logic [7:0] age_ff; // cycles since the last power-up

    // ************************************************
    // reference start-up
    // ************************************************
    // restarts on every enable, saturates to avoid wrap
    always_ff @(posedge clock_i) begin
        if (!ctrl_i.power_en) begin
            age_ff <= 8'h00;
        end else if (age_ff != 8'hff) begin
            age_ff <= age_ff + 8'h01;
        end
    end
    // fixed start-up time, counted in cycles of the register clock
    assign stat_o.ref_ready = ctrl_i.power_en && (age_ff >= settle_i);
    // unpowered comparator reads low, not its last value
    assign stat_o.trip = ctrl_i.power_en && supply_low_i;
endmodule

// ===== tb/vdet_ctrl_bench.sv
// self-checking bench of the low-voltage detect controller
// assumes the analog model above and the bound port checker
`timescale 1ns/1ps
module vdet_ctrl_bench import vdet_pkg::*;;
    typedef struct packed {
        logic [5:0] a; // offset
        logic [7:0] d; // written
        logic [7:0] e; // read back
    } vdet_row_t;
    logic clock_i, sys_rst_i, clk_en_i, avs_read_i, avs_write_i;
    logic [5:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic avs_waitrequest_o, sleep_i, wake_o, vector_req_o;
    logic vector_high_prio_o, irq_o, supply_low;
    vdet_ana_stat_t ana_stat;
    vdet_ana_ctrl_t ana_ctrl;
    logic [7:0] settle, q; // start-up cycles; last read data
    int n_errors, tests_run;
    // awkward rows mixed in
    vdet_row_t rows [11] = '{
        '{VDET_OFF_CTRL, 8'h03, 8'h03}, '{VDET_OFF_CTRL, 8'h0f, 8'h03},
        '{VDET_OFF_CTRL, 8'h2e, 8'h0e}, '{VDET_OFF_CTRL, 8'h00, 8'h00},
        '{VDET_OFF_FLAGS, 8'h04, 8'h04}, '{VDET_OFF_FLAGS, 8'h00, 8'h00},
        '{VDET_OFF_ENABLES, 8'h04, 8'h04}, '{VDET_OFF_PRIO, 8'h04, 8'h04},
        '{VDET_OFF_CORE, 8'h80, 8'h80}, '{VDET_OFF_EVT_EN, 8'h03, 8'h03},
        '{6'h20, 8'hff, 8'h00}};

    vdet_ctrl u_vdet_ctrl (.clock_i, .sys_rst_i, .clk_en_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
        .avs_readdata_o, .avs_waitrequest_o, .ana_stat_i(ana_stat),
        .ana_ctrl_o(ana_ctrl), .sleep_i, .wake_o, .vector_req_o,
        .vector_high_prio_o, .irq_o);
    vdet_ana_model u_vdet_ana_model (.clock_i, .ctrl_i(ana_ctrl),
        .settle_i(settle), .supply_low_i(supply_low), .stat_o(ana_stat));

    // ************************************************
    // clock and shared tasks
    // ************************************************
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // closing report
    task automatic end_of_test();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] e,
        input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", what, e, g);
            n_errors++;
        end
    endtask
    // one avalon transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [5:0] a,
        input logic [7:0] d, input logic [3:0] be);
        int n;
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= be;
        n = 0;
        // sampled at the taking edge, before its updates land
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 20) begin
            check("bus answer", 8'h00, 8'h01);
            end_of_test();
        end
        @(posedge clock_i);
    endtask
    // bounded wait for a register value
    task automatic poll(input logic [5:0] a, input logic [7:0] e);
        int k;
        k = 0;
        do begin
            bus(1'b0, a, 8'h00, 4'h1);
            k++;
        end while (q !== e && k < 60);
        check("polled register", e, q);
        if (k >= 60) end_of_test();
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'h1);
        check("register read", e, q);
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {sys_rst_i, clk_en_i} = 2'b11;
        {avs_read_i, avs_write_i, sleep_i, supply_low} = 4'h0;
        avs_address_i = 6'h00;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'h1;
        settle = 8'd60;
        n_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        // table of write then read back
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, 4'h1);
            rd_chk(rows[i].a, rows[i].e);
        end
        check("priority out", 8'h01, {7'h0, vector_high_prio_o});
        $display("test register table done");
        // mid-run reset, then ignored byte lane
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        rd_chk(VDET_OFF_CTRL, {4'h0, VDET_TRIP_RST});
        rd_chk(VDET_OFF_ENABLES, 8'h00);
        bus(1'b1, VDET_OFF_CTRL, 8'h13, 4'h0);
        rd_chk(VDET_OFF_CTRL, {4'h0, VDET_TRIP_RST});
        check("power out", 8'h00, {7'h0, ana_ctrl.power_en});
        $display("test reset done");
        // set-up order, supply low in start-up
        supply_low <= 1'b1;
        bus(1'b1, VDET_OFF_CTRL, 8'h07, 4'h1);
        bus(1'b1, VDET_OFF_CTRL, 8'h17, 4'h1);
        bus(1'b1, VDET_OFF_FLAGS, 8'h00, 4'h1);
        bus(1'b1, VDET_OFF_ENABLES, 8'h04, 4'h1);
        bus(1'b1, VDET_OFF_CORE, 8'h80, 4'h1);
        bus(1'b1, VDET_OFF_EVT_EN, 8'h03, 4'h1);
        rd_chk(VDET_OFF_CTRL, 8'h17);
        rd_chk(VDET_OFF_FLAGS, 8'h00);
        check("vector early", 8'h00, {7'h0, vector_req_o});
        poll(VDET_OFF_CTRL, 8'h37);
        poll(VDET_OFF_FLAGS, 8'h04);
        check("vector", 8'h01, {7'h0, vector_req_o});
        rd_chk(VDET_OFF_EVT_STAT, 8'h03);
        check("irq", 8'h01, {7'h0, irq_o});
        $display("test settle and trip done");
        // supply recovers: flag sticky, events clear
        supply_low <= 1'b0;
        repeat (6) @(posedge clock_i);
        rd_chk(VDET_OFF_FLAGS, 8'h04);
        bus(1'b1, VDET_OFF_EVT_CLR, 8'h03, 4'h1);
        rd_chk(VDET_OFF_EVT_STAT, 8'h00);
        check("irq cleared", 8'h00, {7'h0, irq_o});
        bus(1'b1, VDET_OFF_FLAGS, 8'h00, 4'h1);
        rd_chk(VDET_OFF_FLAGS, 8'h00);
        check("vector cleared", 8'h00, {7'h0, vector_req_o});
        $display("test clear done");
        // trip while asleep
        sleep_i <= 1'b1;
        supply_low <= 1'b1;
        poll(VDET_OFF_FLAGS, 8'h04);
        check("wake", 8'h01, {7'h0, wake_o});
        check("sleep vector", 8'h01, {7'h0, vector_req_o});
        bus(1'b1, VDET_OFF_CORE, 8'h00, 4'h1);
        check("no global", 8'h00, {7'h0, vector_req_o});
        check("wake kept", 8'h01, {7'h0, wake_o});
        $display("test sleep done");
        // power off drops stable, trips no longer latch
        bus(1'b1, VDET_OFF_CTRL, 8'h07, 4'h1);
        rd_chk(VDET_OFF_CTRL, 8'h07);
        check("power off", 8'h00, {7'h0, ana_ctrl.power_en});
        bus(1'b1, VDET_OFF_FLAGS, 8'h00, 4'h1);
        repeat (6) @(posedge clock_i);
        rd_chk(VDET_OFF_FLAGS, 8'h00);
        check("wake off", 8'h00, {7'h0, wake_o});
        $display("test power off done");
        end_of_test();
    end
endmodule
